// ===== core/input_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous pin
module input_sync
  import uart_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      level_out
);

  logic stage_a;
  logic stage_b;
  logic stage_c;

  // ==========================================================
  // Shift chain; only stage_b reads stage_a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_a <= 1'b1;
      stage_b <= 1'b1;
      stage_c <= 1'b1;
    end else if (clk_en) begin
      stage_a <= pin_in;
      stage_b <= stage_a;
      stage_c <= stage_b;
    end
  end

  // Accept a change only once the two late stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_out <= 1'b1;
    end else if (clk_en && (stage_b == stage_c)) begin
      level_out <= stage_c;
    end
  end

endmodule : input_sync

// ===== core/rate_tick.sv
// Programmable divider giving the sixteen-times-baud receive tick
module rate_tick
  import uart_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic [7:0] divisor,
  output logic            tick
);

  logic [7:0] count;

  // ==========================================================
  // One pulse every divisor+1 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (clk_en) begin
      if (count >= divisor) begin
        count <= 8'h00;
        tick  <= 1'b1;
      end else begin
        count <= count + 8'h01;
        tick  <= 1'b0;
      end
    end
  end

endmodule : rate_tick

// ===== core/uart_pkg.sv
// Shared constants, register map and types of the serial transceiver core
package uart_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] BAUD_IDX   = 8'h0D;
  localparam logic [7:0] CTRL1_IDX  = 8'h0E;
  localparam logic [7:0] CTRL2_IDX  = 8'h0F;
  localparam logic [7:0] STATUS_IDX = 8'h10;
  localparam logic [7:0] DATA_IDX   = 8'h11;
  localparam int         ADDR_SHIFT = 2;

  // ==========================================================
  // Field positions
  localparam int LAST_BIT_CLOCK_EN_BIT  = 0;   // control_one: last bit clock
  localparam int PHASE_BIT = 1;   // control_one: clock phase
  localparam int IDLE_BIT  = 2;   // control_one: clock idle level
  localparam int NINE_BIT  = 4;   // control_one: nine data bits
  localparam int T8_BIT    = 6;   // control_one: ninth transmit bit
  localparam int R8_BIT    = 7;   // control_one: ninth received bit
  localparam int SBK_BIT   = 0;   // control_two: send break
  localparam int RE_BIT    = 2;   // control_two: receiver enable
  localparam int TE_BIT    = 3;   // control_two: transmitter enable
  localparam int FE_BIT    = 1;   // status_reg
  localparam int NF_BIT    = 2;
  localparam int RXF_BIT   = 5;
  localparam int TC_BIT    = 6;
  localparam int TXE_BIT   = 7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [7:0] BAUD_RESET  = 8'h04;

  // ==========================================================
  // Receive tick positions inside a bit (value is tick number minus one)
  localparam logic [3:0] RT_VERIFY_A = 4'h2;   // tick 3
  localparam logic [3:0] RT_VERIFY_B = 4'h4;   // tick 5
  localparam logic [3:0] RT_VERIFY_C = 4'h6;   // tick 7
  localparam logic [3:0] RT_SAMPLE_A = 4'h7;   // tick 8
  localparam logic [3:0] RT_SAMPLE_B = 4'h8;   // tick 9
  localparam logic [3:0] RT_SAMPLE_C = 4'h9;   // tick 10
  localparam logic [3:0] RT_LAST     = 4'hF;   // tick 16
  localparam logic [3:0] RT_FIRST    = 4'h0;
  localparam logic [3:0] HALF_BIT    = 4'h8;

  // Frame lengths in bits with start and stop included, data lengths without them
  localparam logic [3:0] FRAME8 = 4'hA;
  localparam logic [3:0] FRAME9 = 4'hB;
  localparam logic [3:0] DATA8  = 4'h8;
  localparam logic [3:0] DATA9  = 4'h9;

  // ==========================================================
  // Types
  typedef struct packed {
    logic noise;
    logic framing;
  } rx_err_type;

  typedef struct packed {
    logic last_bit_clock_en;
    logic phase;
    logic idle_level;
    logic nine;
  } clk_cfg_type;

endpackage : uart_pkg

// ===== core/uart_sync_core.sv
// Serial transceiver core: oversampling receiver, transmitter, gated clock, APB registers
//
// The APB register port was chosen for this implementation.
module uart_sync_core
  import uart_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_rx_in,
  output logic             tx_out,
  output logic             tx_out_en,
  output logic             sclk_out,
  output logic             sclk_out_en
);

  // ==========================================================
  // Helpers
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  function automatic logic differ3(input logic a, input logic b, input logic c);
    differ3 = !((a == b) && (b == c));
  endfunction : differ3

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
    hit = (addr == 8'((idx << ADDR_SHIFT)));
  endfunction : hit

  typedef enum logic [3:0] {
    RX_HUNT   = 4'b0001,
    RX_VERIFY = 4'b0010,
    RX_BITS   = 4'b0100,
    RX_HOLD1  = 4'b1000
  } rx_state_type;

  typedef enum logic [4:0] {
    TX_OFF   = 5'b00001,
    TX_PREAM = 5'b00010,
    TX_READY = 5'b00100,
    TX_FRAME = 5'b01000,
    TX_BREAK = 5'b10000
  } tx_state_type;

  // ==========================================================
  // Registers and wires
  logic [7:0]   control_one;
  logic [7:0]   control_two;
  logic [7:0]   baud_div;
  logic [7:0]   rx_holding;
  logic [7:0]   tx_holding;
  logic         rx_full_flag;
  logic         tx_empty_flag;
  logic         tx_done_flag;
  rx_err_type   rx_err;
  clk_cfg_type  clk_cfg;
  logic         rx_tick;
  logic         rx_line;
  logic         access;
  logic         wr_data;
  logic         rd_data;
  logic         mapped;
  logic [7:0]   read_mux;

  assign clk_cfg = '{last_bit_clock_en: control_one[LAST_BIT_CLOCK_EN_BIT], phase: control_one[PHASE_BIT],
                     idle_level: control_one[IDLE_BIT], nine: control_one[NINE_BIT]};
  assign access  = psel && penable && pready;
  assign wr_data = access && pwrite && hit(paddr, DATA_IDX);
  assign rd_data = access && !pwrite && hit(paddr, DATA_IDX);
  assign mapped  = hit(paddr, BAUD_IDX) || hit(paddr, CTRL1_IDX) || hit(paddr, CTRL2_IDX)
                || hit(paddr, STATUS_IDX) || hit(paddr, DATA_IDX);

  rate_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .divisor (baud_div),
    .tick    (rx_tick)
  );

  input_sync u_rx_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .pin_in    (serial_rx_in),
    .level_out (rx_line)
  );

  // ==========================================================
  // APB handshake: one wait state, then pready for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata  <= (psel && penable && !pready && !pwrite) ? {24'h00_0000, read_mux} : prdata;
    end
  end

  // Read decode; unmapped and reserved bits read as zero
  always_comb begin
    read_mux = 8'h00;
    if (hit(paddr, BAUD_IDX)) begin
      read_mux = baud_div;
    end else if (hit(paddr, CTRL1_IDX)) begin
      read_mux = control_one;
    end else if (hit(paddr, CTRL2_IDX)) begin
      read_mux = control_two;
    end else if (hit(paddr, STATUS_IDX)) begin
      read_mux[TXE_BIT] = tx_empty_flag;
      read_mux[TC_BIT]  = tx_done_flag;
      read_mux[RXF_BIT] = rx_full_flag;
      read_mux[NF_BIT]  = rx_err.noise;
      read_mux[FE_BIT]  = rx_err.framing;
    end else if (hit(paddr, DATA_IDX)) begin
      read_mux = rx_holding;
    end
  end

  // Control registers; options should stay put while transmitting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_two <= CTRL2_RESET;
      baud_div    <= BAUD_RESET;
    end else if (clk_en && access && pwrite) begin
      if (hit(paddr, CTRL2_IDX)) begin
        control_two <= pwdata[7:0] & 8'h0D;
      end
      if (hit(paddr, BAUD_IDX)) begin
        baud_div <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Receiver
  rx_state_type rx_state;
  logic [3:0]   rt_pos;
  logic [3:0]   bit_pos;
  logic [2:0]   samples;
  logic [8:0]   rx_shift;
  logic         frame_noise;
  logic         rx_on;
  logic [3:0]   rx_stop_pos;
  logic         vote;
  logic         vote_noise;
  logic         is_break;
  logic         rx_commit;
  logic [7:0]   rx_byte;
  logic         rx_ninth;

  assign rx_on       = control_two[RE_BIT];
  assign rx_stop_pos = clk_cfg.nine ? DATA9 + 4'h1 : DATA8 + 4'h1;
  assign vote        = maj3(samples[0], samples[1], rx_line);
  assign vote_noise  = differ3(samples[0], samples[1], rx_line);
  assign rx_byte     = clk_cfg.nine ? rx_shift[7:0] : rx_shift[8:1];
  assign rx_ninth    = clk_cfg.nine && rx_shift[8];
  assign is_break    = !vote && (rx_byte == 8'h00) && !rx_ninth;
  assign rx_commit   = rx_tick && (rx_state == RX_BITS) && (rt_pos == RT_SAMPLE_C)
                    && (bit_pos == rx_stop_pos);

  // Receive sequencer, stepped by rx_tick; forced to RX_HUNT on any cycle while RE is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state    <= RX_HUNT;
      rt_pos      <= RT_FIRST;
      bit_pos     <= 4'h0;
      samples     <= 3'b111;
      rx_shift    <= 9'h000;
      frame_noise <= 1'b0;
    end else if (clk_en && !rx_on) begin
      rx_state <= RX_HUNT;
    end else if (clk_en && rx_tick) begin
      rt_pos <= rt_pos + 4'h1;
      unique case (rx_state)
        RX_HUNT: begin
          if (!rx_line) begin
            rx_state <= RX_VERIFY;
            rt_pos   <= RT_FIRST + 4'h1;
          end
        end
        RX_VERIFY: begin
          if (rt_pos == RT_VERIFY_A) samples[0] <= rx_line;
          if (rt_pos == RT_VERIFY_B) samples[1] <= rx_line;
          if (rt_pos == RT_VERIFY_C) begin
            if (!vote) begin
              rx_state    <= RX_BITS;
              bit_pos     <= 4'h0;
              frame_noise <= vote_noise;
            end else begin
              rx_state <= RX_HUNT;
            end
          end
        end
        RX_BITS: begin
          if (rt_pos == RT_SAMPLE_A) samples[0] <= rx_line;
          if (rt_pos == RT_SAMPLE_B) samples[1] <= rx_line;
          if (rt_pos == RT_SAMPLE_C) begin
            frame_noise <= frame_noise | vote_noise;
            if (bit_pos == 4'h0 && vote) begin
              rx_state <= RX_HUNT;
            end else if (bit_pos != 4'h0 && bit_pos != rx_stop_pos) begin
              rx_shift <= {vote, rx_shift[8:1]};
            end
            if (bit_pos == rx_stop_pos) begin
              if (vote) begin
                rx_state <= RX_HUNT;
              end else if (is_break) begin
                rx_state <= RX_HOLD1;
              end
            end
          end
          if (rt_pos == RT_LAST) begin
            bit_pos <= bit_pos + 4'h1;
            if (bit_pos == rx_stop_pos) begin
              // Artificial start: qualifiers forced to one, stop taken as one
              bit_pos     <= 4'h0;
              samples     <= 3'b111;
              frame_noise <= 1'b0;
            end
          end
        end
        RX_HOLD1: begin
          if (rx_line) begin
            rx_state <= RX_HUNT;
          end
        end
      endcase
    end
  end

  // Holding register and receive flags; a set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_holding   <= DATA_RESET;
      rx_full_flag <= 1'b0;
      rx_err       <= '{noise: 1'b0, framing: 1'b0};
      control_one  <= CTRL1_RESET;
    end else if (clk_en) begin
      if (access && pwrite && hit(paddr, CTRL1_IDX)) begin
        control_one[6:0] <= pwdata[6:0] & 7'h57;
      end
      if (rd_data) begin
        rx_full_flag <= 1'b0;
        rx_err       <= '{noise: 1'b0, framing: 1'b0};
      end
      if (rx_commit) begin
        rx_holding          <= rx_byte;
        control_one[R8_BIT] <= rx_ninth;
        rx_full_flag        <= 1'b1;
        rx_err.noise        <= frame_noise | vote_noise;
        rx_err.framing      <= !vote;
      end
    end
  end

  // ==========================================================
  // Transmitter
  tx_state_type tx_state;
  logic [3:0]   tx_div;
  logic [3:0]   tx_pos;
  logic [8:0]   tx_shift;
  logic         te_prev;
  logic         restart;
  logic         te;
  logic         bit_tick;
  logic [3:0]   frame_len;
  logic [3:0]   last_data;
  logic         next_line;
  logic         clk_active;

  assign te        = control_two[TE_BIT];
  assign bit_tick  = rx_tick && (tx_div == RT_LAST);
  assign frame_len = clk_cfg.nine ? FRAME9 : FRAME8;
  assign last_data = clk_cfg.nine ? DATA9 : DATA8;

  // Transmit sequencer; every decision except leaving TX_OFF lands on a bit boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state      <= TX_OFF;
      tx_div        <= RT_FIRST;
      tx_pos        <= 4'h0;
      tx_shift      <= 9'h1FF;
      te_prev       <= 1'b0;
      restart       <= 1'b0;
      tx_holding    <= DATA_RESET;
      tx_empty_flag <= 1'b1;
      tx_done_flag  <= 1'b1;
    end else if (clk_en) begin
      te_prev <= te;
      if (wr_data) begin
        tx_holding    <= pwdata[7:0];
        tx_empty_flag <= 1'b0;
        tx_done_flag  <= 1'b0;
      end
      if (te && !te_prev && tx_state != TX_OFF) begin
        restart <= 1'b1;
      end
      if (tx_state == TX_OFF) begin
        tx_div <= RT_FIRST;
        if (te) begin
          tx_state <= TX_PREAM;
          tx_pos   <= 4'h0;
        end
      end else if (rx_tick) begin
        tx_div <= tx_div + 4'h1;
      end
      if (bit_tick) begin
        tx_pos <= tx_pos + 4'h1;
        unique case (tx_state)
          TX_OFF: begin
          end
          TX_PREAM: begin
            if (tx_pos == frame_len - 4'h1) tx_state <= TX_READY;
          end
          TX_FRAME: begin
            if (tx_pos != 4'h0) tx_shift <= {1'b1, tx_shift[8:1]};
          end
          TX_BREAK: begin
          end
          TX_READY: begin
          end
        endcase
        // Frame boundary: choose what follows the bit just ended
        if (tx_state == TX_READY || (tx_state != TX_PREAM && tx_pos == frame_len - 4'h1)) begin
          tx_pos <= 4'h0;
          if (restart) begin
            tx_state <= TX_PREAM;
            restart  <= 1'b0;
          end else if (!te) begin
            tx_state     <= TX_OFF;
            tx_done_flag <= 1'b1;
          end else if (control_two[SBK_BIT]) begin
            tx_state <= TX_BREAK;
          end else if (!tx_empty_flag) begin
            tx_state      <= TX_FRAME;
            tx_shift      <= {control_one[T8_BIT], tx_holding};
            tx_empty_flag <= 1'b1;
          end else begin
            tx_state     <= TX_READY;
            tx_done_flag <= 1'b1;
          end
        end
      end
    end
  end

  // Line level for the current state
  always_comb begin
    next_line = 1'b1;
    if (tx_state == TX_BREAK) begin
      next_line = 1'b0;
    end else if (tx_state == TX_FRAME && tx_pos == 4'h0) begin
      next_line = 1'b0;
    end else if (tx_state == TX_FRAME && tx_pos <= last_data) begin
      next_line = tx_shift[0];
    end
  end

  // Clock pulse only inside data bits, last one by option
  always_comb begin
    clk_active = 1'b0;
    if (tx_state == TX_FRAME && tx_pos != 4'h0 && tx_pos <= last_data
        && (tx_pos != last_data || clk_cfg.last_bit_clock_en)) begin
      clk_active = clk_cfg.phase ? (tx_div < HALF_BIT) : (tx_div >= HALF_BIT);
    end
  end

  // Pin drivers; enables drop when the transmitter stands off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out      <= 1'b1;
      tx_out_en   <= 1'b0;
      sclk_out    <= 1'b0;
      sclk_out_en <= 1'b0;
    end else if (clk_en) begin
      tx_out      <= next_line;
      tx_out_en   <= (tx_state != TX_OFF);
      sclk_out    <= clk_cfg.idle_level ^ clk_active;
      sclk_out_en <= (tx_state != TX_OFF);
    end
  end

endmodule : uart_sync_core

// ===== test/serial_peer_model.sv
// Remote peer: frame sender and timed mid-bit receiver that counts clock pin edges
module serial_peer_model (
  input  wire logic  pclk,
  input  wire logic  tx_out,
  input  wire logic  tx_out_en,
  input  wire logic  sclk_out,
  output logic       serial_rx_in,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_pulses,
  output int         rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 80;  // Default rate: 16 ticks of 5 cycles
  logic sq;
  int   ed;
  // ==========================================================
  // Sender; optional glitch spans one tick so it hits a single vote
  task send(input logic [9:0] b, input int g);
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < BIT; c++) begin
        serial_rx_in <= b[i] ^ (i == g && c >= 44 && c <= 48);
        @(posedge pclk);
      end
    end
  endtask
  // Cycle wait that counts clock pin edges
  task tk(input int n);
    repeat (n) begin
      @(posedge pclk);
      if (sclk_out !== sq) ed++;
      sq = sclk_out;
    end
  endtask
  // ==========================================================
  // Receiver samples mid-bit, LSB first
  initial begin
    serial_rx_in = 1'b1;
    rx_count = 0;
    rx_byte = 8'h00;
    rx_pulses = 8'h00;
    sq = 1'b0;
    forever begin
      tk(1);
      if (tx_out_en && !tx_out) begin
        ed = 0;
        tk(BIT / 2);
        for (int i = 0; i < 8; i++) begin
          tk(BIT);
          rx_byte[i] = tx_out;
        end
        tk(BIT);
        rx_pulses = 8'(ed / 2);
        rx_count++;
      end
    end
  end
endmodule : serial_peer_model

// ===== test/uart_sampling_and_sync_clock_tb_top.sv
// Self-checking bench of the serial transceiver core
module uart_sampling_and_sync_clock_tb_top
  import uart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, er, pready, pslverr;
  logic        rxd, txd, txe, sck, ske;
  logic [7:0]  paddr, d, e, f, pb, pp;
  logic [31:0] pwdata, prdata, q;
  int          pc, n, n_errors = 0, n_tests = 0, cyc = 0;

  uart_sync_core dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_rx_in(rxd), .tx_out(txd),
    .tx_out_en(txe), .sclk_out(sck), .sclk_out_en(ske));
  serial_peer_model peer_u (.pclk(pclk), .tx_out(txd), .tx_out_en(txe), .sclk_out(sck),
    .serial_rx_in(rxd), .rx_byte(pb), .rx_pulses(pp), .rx_count(pc));

  // ==========================================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      finish_test();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // APB master: holds the request until ready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    presetn = 1'b0;
    void'($urandom(32'h2389));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h44, 32'h0);
    rd(8'h40, 32'hC0);
    apb(1'b0, 8'h00, 32'h0);
    check(er, 1'b1);
    // Three frames, the middle one with a single disagreeing vote
    apb(1'b1, 8'h3C, 32'h04);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      peer_u.send({1'b1, d, 1'b0}, (i == 1) ? 3 : -1);
      rd(8'h40, (i == 1) ? 32'hE4 : 32'hE0);
      rd(8'h44, d);
    end
    // Bad stop, next frame straight after it
    d = 8'($urandom) | 8'h01;
    e = 8'($urandom);
    peer_u.send({1'b0, d, 1'b0}, -1);
    fork
      peer_u.send({1'b1, e, 1'b0}, -1);
      begin
        rd(8'h40, 32'hE2);
        rd(8'h44, d);
      end
    join
    rd(8'h44, e);
    // Break, then line high before a new start counts
    peer_u.send(10'h000, -1);
    peer_u.send(10'h3FF, -1);
    rd(8'h40, 32'hE2);
    rd(8'h44, 32'h0);
    // Every clock option set while idle, frames sent back to back
    for (int c = 0; c < 8; c++) begin
      d = 8'($urandom);
      e = 8'($urandom);
      f = 8'($urandom);
      fork
        peer_u.send({1'b1, f, 1'b0}, -1);
      join_none
      apb(1'b1, 8'h38, c);
      apb(1'b1, 8'h3C, 32'h0C);
      n = pc;
      apb(1'b1, 8'h44, d);
      do apb(1'b0, 8'h40, 32'h0); while (q[7] !== 1'b1);
      apb(1'b1, 8'h44, e);
      rd(8'h44, f);
      while (pc != n + 1) @(posedge pclk);
      check(pb, d);
      check(pp, c[0] ? 8'd8 : 8'd7);
      while (pc != n + 2) @(posedge pclk);
      check(pb, e);
      check(sck, c[2]);
      apb(1'b1, 8'h3C, 32'h04);
      // Stop bit still running: pins let go only at the frame boundary
      repeat (100) if (txe) @(posedge pclk);
      check(txe, 1'b0);
    end
    finish_test();
  end
endmodule : uart_sampling_and_sync_clock_tb_top

// ===== test/uart_sync_core_assertions.sv
// Port-level checks of the serial transceiver core
module uart_sync_core_assertions
  import uart_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_out,
  input wire logic        tx_out_en,
  input wire logic        sclk_out,
  input wire logic        sclk_out_en
);
  // ==========================================================
  // Register bus
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_MAP: assert property (pready |->
    pslverr == !(paddr inside {8'h34, 8'h38, 8'h3C, 8'h40, 8'h44}))
    else $error("error flag does not match address map");
  AST_HIGH_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  // ==========================================================
  // Serial pins; a bit lasts far longer than eight cycles
  AST_EN_PAIR: assert property (sclk_out_en == tx_out_en)
    else $error("clock and data enables differ");
  AST_PREAMBLE: assert property ($rose(tx_out_en) |-> ##2 (tx_out && $stable(sclk_out)) [*8])
    else $error("preamble not quiet ones");
  AST_BIT_MIN: assert property (tx_out_en && $changed(tx_out) |=> $stable(tx_out) [*7])
    else $error("data bit too short");
  AST_PULSE_HALF: assert property (sclk_out_en && $changed(sclk_out) |=> $stable(sclk_out) [*8])
    else $error("clock half period too short");
  // Main scenarios reached
  cover property (tx_out_en && $fell(tx_out));
  cover property (pslverr);
  cover property (sclk_out_en && $changed(sclk_out));
endmodule : uart_sync_core_assertions

bind uart_sync_core uart_sync_core_assertions chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_out(tx_out), .tx_out_en(tx_out_en), .sclk_out(sclk_out),
  .sclk_out_en(sclk_out_en));
